// >>> pkg/eec_pkg.sv
// Types shared by the error counter bank
`default_nettype none
`include "eec_regs.svh"

package eec_pkg;

  // Event pulses from the receive framer, pattern checker and slip buffer
  typedef struct packed {
    logic pattern_err;
    logic tx_slip;
    logic zero_viol;
  } eec_events_t;

  // Whole state of the counter bank
  typedef struct packed {
    logic [15:0] pattern_error_count;
    logic [7:0] pattern_low_snap;
    logic [7:0] tx_slip_count;
    logic [15:0] zero_violation_count;
    logic [7:0] zero_low_snap;
    logic [`EEC_IRQ_W-1:0] irq_status;
    logic [`EEC_IRQ_W-1:0] irq_mask;
    logic [`EEC_DATA_W-1:0] rdata;
    logic irq;
  } eec_state_t;

endpackage
`default_nettype wire

// >>> pkg/eec_regs.svh
// Register offsets, field positions, reset values and widths of the error counter bank
`ifndef EEC_REGS_SVH
`define EEC_REGS_SVH

// Bus widths
`define EEC_ADDR_W 12
`define EEC_DATA_W 8

// Register offsets within one channel
`define EEC_PAT_HI_OFF 12'h90d
`define EEC_PAT_LO_OFF 12'h90e
`define EEC_SLIP_OFF 12'h90f
`define EEC_ZV_HI_OFF 12'h910
`define EEC_ZV_LO_OFF 12'h911
`define EEC_IRQ_STAT_OFF 12'h912
`define EEC_IRQ_MASK_OFF 12'h913

// Interrupt status and mask bit positions
`define EEC_IRQ_PAT_BIT 0
`define EEC_IRQ_SLIP_BIT 1
`define EEC_IRQ_ZV_BIT 2
`define EEC_IRQ_W 3

// Reset values
`define EEC_CNT16_RST 16'h0000
`define EEC_CNT8_RST 8'h00
`define EEC_IRQ_RST 3'h0
`define EEC_RDATA_RST 8'h00

// Saturation limits
`define EEC_CNT16_MAX 16'hffff
`define EEC_CNT8_MAX 8'hff

`endif

// >>> sim/eec_chk.sv
// Port assertions for the error counter bank
`timescale 1ns/1ps
`default_nettype none
module eec_chk (
  input wire logic i_clk, // Clock
  input wire logic i_rst, // Reset
  input wire logic [11:0] i_addr, // Offset
  input wire logic [7:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  input wire eec_pkg::eec_events_t i_events, // Events
  input wire logic [7:0] o_rdata, // Read data
  input wire logic o_irq // Interrupt
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Idle levels, decoding, read clears and status write clear
  AST_RST_ZERO: assert property (
    $fell(i_rst) |-> o_rdata == 8'h00 && !o_irq) else $error("reset");
  AST_IDLE_ZERO: assert property (
    !$past(i_rd) |-> o_rdata == 8'h00) else $error("idle");
  AST_UNMAPPED: assert property (
    $past(i_rd) && $past(i_addr) > 12'h913 |-> o_rdata == 8'h00) else $error("unmap");
  AST_SLIP_CLR: assert property (
    i_rd && i_addr == 12'h90f && !i_events.tx_slip ##1 i_rd && i_addr == 12'h90f
    |=> o_rdata == 8'h00) else $error("slip clr");
  AST_SLIP_ONE: assert property (
    i_rd && i_addr == 12'h90f && i_events.tx_slip ##1 i_rd && i_addr == 12'h90f
    |=> o_rdata == 8'h01) else $error("slip one");
  AST_PAT_CLR: assert property (
    i_rd && i_addr == 12'h90d && !i_events.pattern_err ##1 i_rd && i_addr == 12'h90d
    |=> o_rdata == 8'h00) else $error("pat clr");
  AST_ZV_CLR: assert property (
    i_rd && i_addr == 12'h910 && !i_events.zero_viol ##1 i_rd && i_addr == 12'h910
    |=> o_rdata == 8'h00) else $error("zv clr");
  AST_LO_CLR: assert property (
    i_rd && i_addr == 12'h90e ##1 i_rd && i_addr == 12'h90e |=> o_rdata == 8'h00)
    else $error("lo clr");
  AST_STAT_CLR: assert property (
    i_wr && i_addr == 12'h912 && i_wdata[2:0] == 3'h7 && i_events == 3'h0 |=> !o_irq)
    else $error("stat clr");
endmodule
bind eec_counters eec_chk eec_chk_i (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_events(i_events), .o_rdata(o_rdata),
  .o_irq(o_irq));
`default_nettype wire

// >>> sim/eec_host.sv
// Host bus master model for the counter bank
`timescale 1ns/1ps
`default_nettype none
module eec_host (
  input wire logic i_clk, // Clock
  output logic [11:0] o_addr, // Offset
  output logic [7:0] o_wdata, // Write data
  output logic o_wr, // Write strobe
  output logic o_rd // Read strobe
);
  initial {o_addr, o_wdata, o_wr, o_rd} = '0;
  // One bus cycle; callers read the high byte before the low byte
  task acc(input logic [1:0] m, input logic [11:0] a, input logic [7:0] d);
    {o_wr, o_rd} <= m;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench for the error counter bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_clk, i_rst, wr, rd, o_irq;
  logic [11:0] addr;
  logic [7:0] wdata, o_rdata;
  eec_pkg::eec_events_t ev;
  logic [7:0] q[$];
  logic [31:0] s = 32'hdb8a;
  logic [15:0] c;
  bit pend;
  int err_total, cmp_count, n[3];
  eec_host eec_host_i (.i_clk(i_clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  eec_counters eec_counters_i (.i_clk(i_clk), .i_rst(i_rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .i_events(ev), .o_rdata(o_rdata), .o_irq(o_irq));
  function automatic logic [31:0] lf(input logic [31:0] v);
    return v[0] ? (v >> 1) ^ 32'h80200003 : v >> 1;
  endfunction
  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task rd8(input logic [11:0] a, input logic [7:0] e);
    q.push_back(e);
    eec_host_i.acc(2'b01, a, 8'h00);
  endtask
  task see_irq(input logic e);
    repeat (2) eec_host_i.acc(2'b00, 12'h000, 8'h00);
    @(negedge i_clk);
    chk({7'h00, o_irq}, {7'h00, e});
    @(posedge i_clk);
  endtask
  task finish_test();
    $display("Compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // Each answer checked against the oldest note
  always @(posedge i_clk) begin
    if (pend)
      chk(o_rdata, q.pop_front());
    pend = rd;
  end
  initial begin
    #800000;
    err_total++;
    finish_test();
  end
  initial begin
    i_rst = 1'b1;
    ev = '0;
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    // All offsets read zero after reset, an unmapped one too
    for (int a = 12'h90d; a <= 12'h914; a++)
      rd8(a[11:0], 8'h00);
    // Random event bursts, tallied per source
    repeat (800) begin
      s = lf(s);
      ev <= eec_pkg::eec_events_t'(s[2:0]);
      for (int k = 0; k < 3; k++)
        n[k] += s[k];
      eec_host_i.acc(2'b00, 12'h000, 8'h00);
    end
    ev <= '0;
    // High byte first, then low; repeated reads of each half find it cleared
    for (int i = 0; i < 2; i++) begin
      c = n[2 - 2 * i][15:0];
      rd8(i ? 12'h910 : 12'h90d, c[15:8]);
      rd8(i ? 12'h911 : 12'h90e, c[7:0]);
      rd8(i ? 12'h911 : 12'h90e, 8'h00);
      rd8(i ? 12'h910 : 12'h90d, 8'h00);
      rd8(i ? 12'h910 : 12'h90d, 8'h00);
    end
    // Saturated slip count, then clears with and without a slip alongside
    rd8(12'h90f, n[1] > 255 ? 8'hff : n[1][7:0]);
    ev.tx_slip <= 1'b1;
    rd8(12'h90f, 8'h00);
    ev.tx_slip <= 1'b0;
    rd8(12'h90f, 8'h01);
    // Saturation sets status; mask gates the line; writing one clears
    rd8(12'h912, {6'h00, n[1] >= 255, 1'b0});
    see_irq(1'b0);
    eec_host_i.acc(2'b10, 12'h913, 8'h02);
    see_irq(n[1] >= 255);
    eec_host_i.acc(2'b10, 12'h912, 8'h07);
    see_irq(1'b0);
    rd8(12'h913, 8'h02);
    // Every source held high runs all counters into their limits
    ev <= '1;
    repeat (65540) eec_host_i.acc(2'b00, 12'h000, 8'h00);
    ev <= '0;
    rd8(12'h912, 8'h07);
    for (int a = 12'h90d; a <= 12'h911; a++)
      rd8(a[11:0], 8'hff);
    eec_host_i.acc(2'b00, 12'h000, 8'h00);
    repeat (2) @(posedge i_clk);
    finish_test();
  end
endmodule
`default_nettype wire

// >>> src/eec_counters.sv
// Error event counter bank: pattern errors, transmit slips, excessive zeros
`timescale 1ns/1ps
`default_nettype none
`include "eec_regs.svh"

module eec_counters (
  input wire logic i_clk, // 100 MHz framer clock
  input wire logic i_rst, // Asynchronous reset, active high
  input wire logic [`EEC_ADDR_W-1:0] i_addr, // Register offset
  input wire logic [`EEC_DATA_W-1:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe, one cycle
  input wire logic i_rd, // Read strobe, one cycle
  input wire eec_pkg::eec_events_t i_events, // Event pulses, one per cycle
  output logic [`EEC_DATA_W-1:0] o_rdata, // Read data, cycle after strobe
  output logic o_irq // Level interrupt, high while unmasked status set
);

  // Registered state and its next value
  eec_pkg::eec_state_t state_q;
  eec_pkg::eec_state_t state_d;

  // Decoded read and write strokes
  logic rd_pat_hi;
  logic rd_pat_lo;
  logic rd_slip;
  logic rd_zv_hi;
  logic rd_zv_lo;
  logic rd_stat;
  logic rd_mask;
  logic wr_stat;
  logic wr_mask;

  // Saturation events raised this cycle
  logic [`EEC_IRQ_W-1:0] sat_set;

  // Saturating increment of a 16-bit count
  function automatic logic [15:0] inc16(
    input logic [15:0] cnt,
    input logic inc
  );
    logic [15:0] res;
    res = cnt;
    if (inc && (cnt != `EEC_CNT16_MAX)) begin
      res = cnt + 16'h0001;
    end
    return res;
  endfunction

  // Saturating increment of an 8-bit count
  function automatic logic [7:0] inc8(
    input logic [7:0] cnt,
    input logic inc
  );
    logic [7:0] res;
    res = cnt;
    if (inc && (cnt != `EEC_CNT8_MAX)) begin
      res = cnt + 8'h01;
    end
    return res;
  endfunction

  // Address decode of the register strobes
  always_comb begin
    rd_pat_hi = i_rd && (i_addr == `EEC_PAT_HI_OFF);
    rd_pat_lo = i_rd && (i_addr == `EEC_PAT_LO_OFF);
    rd_slip = i_rd && (i_addr == `EEC_SLIP_OFF);
    rd_zv_hi = i_rd && (i_addr == `EEC_ZV_HI_OFF);
    rd_zv_lo = i_rd && (i_addr == `EEC_ZV_LO_OFF);
    rd_stat = i_rd && (i_addr == `EEC_IRQ_STAT_OFF);
    rd_mask = i_rd && (i_addr == `EEC_IRQ_MASK_OFF);
    wr_stat = i_wr && (i_addr == `EEC_IRQ_STAT_OFF);
    wr_mask = i_wr && (i_addr == `EEC_IRQ_MASK_OFF);
  end

  // Next state of the whole bank
  always_comb begin
    state_d = state_q;
    sat_set = `EEC_IRQ_RST;
    state_d.rdata = `EEC_RDATA_RST;

    // Pattern error counter, upper byte read restarts it
    if (rd_pat_hi) begin
      state_d.rdata = state_q.pattern_error_count[15:8];
      state_d.pattern_low_snap = state_q.pattern_error_count[7:0];
      // Event in the read cycle opens the new interval
      state_d.pattern_error_count = inc16(`EEC_CNT16_RST, i_events.pattern_err);
    end else begin
      state_d.pattern_error_count =
        inc16(state_q.pattern_error_count, i_events.pattern_err);
    end

    // Pattern error low byte comes from the snapshot
    if (rd_pat_lo) begin
      state_d.rdata = state_q.pattern_low_snap;
      state_d.pattern_low_snap = `EEC_CNT8_RST;
    end

    // Transmit slip counter, cleared by its own read
    if (rd_slip) begin
      state_d.rdata = state_q.tx_slip_count;
      state_d.tx_slip_count = inc8(`EEC_CNT8_RST, i_events.tx_slip);
    end else begin
      // One pulse per repeated or dropped frame
      state_d.tx_slip_count = inc8(state_q.tx_slip_count, i_events.tx_slip);
    end

    // Zero violation counter, upper byte read restarts it
    if (rd_zv_hi) begin
      state_d.rdata = state_q.zero_violation_count[15:8];
      state_d.zero_low_snap = state_q.zero_violation_count[7:0];
      state_d.zero_violation_count = inc16(`EEC_CNT16_RST, i_events.zero_viol);
    end else begin
      state_d.zero_violation_count =
        inc16(state_q.zero_violation_count, i_events.zero_viol);
    end

    // Zero violation low byte comes from the snapshot
    if (rd_zv_lo) begin
      state_d.rdata = state_q.zero_low_snap;
      state_d.zero_low_snap = `EEC_CNT8_RST;
    end

    // Counters that reach their limit this cycle
    sat_set[`EEC_IRQ_PAT_BIT] =
      (state_d.pattern_error_count == `EEC_CNT16_MAX) &&
      (state_q.pattern_error_count != `EEC_CNT16_MAX);
    sat_set[`EEC_IRQ_SLIP_BIT] =
      (state_d.tx_slip_count == `EEC_CNT8_MAX) &&
      (state_q.tx_slip_count != `EEC_CNT8_MAX);
    sat_set[`EEC_IRQ_ZV_BIT] =
      (state_d.zero_violation_count == `EEC_CNT16_MAX) &&
      (state_q.zero_violation_count != `EEC_CNT16_MAX);

    // Sticky status, write one to clear, new event wins
    if (wr_stat) begin
      state_d.irq_status = state_q.irq_status & ~i_wdata[`EEC_IRQ_W-1:0];
    end
    state_d.irq_status = state_d.irq_status | sat_set;

    // Interrupt mask, one enables the matching status bit
    if (wr_mask) begin
      state_d.irq_mask = i_wdata[`EEC_IRQ_W-1:0];
    end

    // Status and mask read back, upper bits zero
    if (rd_stat) begin
      state_d.rdata = {5'h00, state_q.irq_status};
    end
    if (rd_mask) begin
      state_d.rdata = {5'h00, state_q.irq_mask};
    end

    // Interrupt level from next status and mask
    state_d.irq = |(state_d.irq_status & state_d.irq_mask);
  end

  // State register with constant reset values
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q.pattern_error_count <= `EEC_CNT16_RST;
      state_q.pattern_low_snap <= `EEC_CNT8_RST;
      state_q.tx_slip_count <= `EEC_CNT8_RST;
      state_q.zero_violation_count <= `EEC_CNT16_RST;
      state_q.zero_low_snap <= `EEC_CNT8_RST;
      state_q.irq_status <= `EEC_IRQ_RST;
      state_q.irq_mask <= `EEC_IRQ_RST;
      state_q.rdata <= `EEC_RDATA_RST;
      state_q.irq <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  // Outputs straight from the state register
  assign o_rdata = state_q.rdata;
  assign o_irq = state_q.irq;

endmodule
`default_nettype wire
